// File: timers_pkg.sv
// Constants shared by the timer block: register map, field positions,
// reset values and the small codes that steer the timers.
// Assumes a 12-bit APB byte address and 32-bit data.
package timers_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [11:0] T24_BASE = 12'h000;
  localparam logic [11:0] CAP_CFG_OFF = 12'h020;
  localparam logic [11:0] CAP0_DATA_OFF = 12'h024;
  localparam logic [11:0] CAP1_DATA_OFF = 12'h028;
  localparam logic [11:0] T16_BASE = 12'h040;
  localparam logic [11:0] T16_STRIDE = 12'h020;
  localparam logic [11:0] WD_CTRL_OFF = 12'h100;
  localparam logic [11:0] WD_KEY_OFF = 12'h104;
  localparam logic [11:0] WD_STAT_OFF = 12'h108;

  // Word index of each register inside one timer's window.
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_PRESCALE = 3'h1;
  localparam logic [2:0] IDX_BUF0 = 3'h2;
  localparam logic [2:0] IDX_BUF1 = 3'h3;
  localparam logic [2:0] IDX_COUNT = 3'h4;
  localparam logic [2:0] IDX_ACT0 = 3'h5;
  localparam logic [2:0] IDX_ACT1 = 3'h6;
  localparam logic [2:0] IDX_STATUS = 3'h7;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int F_EN = 0;
  localparam int F_RST_SEL = 1;
  localparam int F_UPD = 3;
  localparam int F_PACT0 = 5;
  localparam int F_PACT1 = 7;
  localparam int F_GPIO = 9;
  localparam int F_IEN = 10;
  localparam int F_SWRST = 16;
  localparam int F_EDGE0 = 0;
  localparam int F_EDGE1 = 2;
  localparam int F_CIEN0 = 4;
  localparam int F_CIEN1 = 5;
  localparam int F_WD_EN = 0;
  localparam int F_WD_RESTART = 0;
  localparam int F_WD_HALF = 0;
  localparam int F_WD_EXPIRED = 1;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [5:0] CAP_CFG_RST = 6'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // Codes
  // ==========================================================
  typedef enum logic [1:0] {
    PIN_NONE = 2'b00, PIN_SET = 2'b01, PIN_CLEAR = 2'b10, PIN_TOGGLE = 2'b11
  } pin_act_e;
  typedef enum logic [1:0] {
    RST_ROLL = 2'b00, RST_CMP0 = 2'b01, RST_CMP1 = 2'b10, RST_SW = 2'b11
  } rst_sel_e;
  typedef enum logic [1:0] {
    UPD_CMP0 = 2'b00, UPD_CMP1 = 2'b01, UPD_EITHER = 2'b10, UPD_RESET = 2'b11
  } upd_e;
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10, EDGE_BOTH = 2'b11
  } edge_e;

endpackage

// File: pwm_timer_core.sv
// One PWM timer: prescaler, counter, two shadowed compares, pin action
// and interrupt pulses. Used for the 24-bit timer and the 16-bit ones.
// Assumes writes arrive as single-cycle strobes from the bus slave.
`timescale 1ns/1ns
module pwm_timer_core #(
  parameter int CW = 16,            // Counter width.
  parameter bit CMP0_PIN = 1'b1     // Compare 0 may act on the pin.
) (
  input wire logic clk,             // Interface clock.
  input wire logic rst_n,           // Synchronous reset, active low.
  input wire logic wr_en,           // One-cycle register write strobe.
  input wire logic [2:0] wr_idx,    // Word index of the write.
  input wire logic [31:0] wdata,    // Write data.
  input wire logic [2:0] rd_idx,    // Word index of the read.
  output logic [31:0] rd_data,      // Read data, combinational.
  output logic [CW-1:0] count,      // Current count.
  input wire logic pin_in,          // Pin level, asynchronous.
  output logic pin_out,             // Pin drive value.
  output logic pin_oe,              // Pin drive enable.
  output logic [2:0] irq            // Pulses: cmp1, cmp0, overflow.
);

  if (CW < 9 || CW > 32) begin : bad_width
    $error("pwm_timer_core: CW must lie between 9 and 32");
  end

  typedef struct packed {
    logic en;
    logic [1:0] rst_sel;
    logic [1:0] upd;
    logic [1:0] pact0;
    logic [1:0] pact1;
    logic gpio;
    logic [2:0] ien;
    logic [7:0] pre;
    logic [7:0] pre_cnt;
    logic [CW-1:0] cnt;
    logic [CW-1:0] buf0;
    logic [CW-1:0] buf1;
    logic [CW-1:0] cmp0;
    logic [CW-1:0] cmp1;
    logic pin;
    logic [1:0] sync;
    logic [2:0] irq;
  } core_s;

  core_s r_reg;
  core_s r_next;
  logic tick;
  logic ovf;
  logic m0;
  logic m1;
  logic upd_ev;

  // Applies one pin action code to the present pin level.
  function automatic logic pin_apply(logic [1:0] act, logic p);
    case (act)
      timers_pkg::PIN_SET: pin_apply = 1'b1;
      timers_pkg::PIN_CLEAR: pin_apply = 1'b0;
      timers_pkg::PIN_TOGGLE: pin_apply = ~p;
      default: pin_apply = p;
    endcase
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  // Counter, compare and register updates all resolve here.
  always_comb begin
    r_next = r_reg;
    r_next.irq = 3'h0;
    r_next.sync = {r_reg.sync[0], pin_in};
    // R18: prescaler divides by value plus one
    tick = r_reg.en && (r_reg.pre_cnt == r_reg.pre);
    if (r_reg.en) begin
      r_next.pre_cnt = tick ? 8'h00 : r_reg.pre_cnt + 8'h01;
    end
    ovf = tick && (r_reg.cnt == '1);
    // R2: compare match events
    m0 = tick && (r_reg.cnt == r_reg.cmp0);
    m1 = tick && (r_reg.cnt == r_reg.cmp1);
    // R5: counter reset source
    if (tick) begin
      if (ovf && r_reg.rst_sel == timers_pkg::RST_SW) begin
        r_next.cnt = r_reg.cnt;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end
    if ((r_reg.rst_sel == timers_pkg::RST_CMP0 && m0) ||
        (r_reg.rst_sel == timers_pkg::RST_CMP1 && m1)) begin
      r_next.cnt = '0;
    end
    // R12: compare pin actions
    if (CMP0_PIN && m0) begin
      r_next.pin = pin_apply(r_reg.pact0, r_reg.pin);
    end
    // R7: second compare drives pin
    if (m1) begin
      r_next.pin = pin_apply(r_reg.pact1, CMP0_PIN && m0 ?
                             r_next.pin : r_reg.pin);
    end
    // R3: shadow loads after match
    case (r_reg.upd)
      timers_pkg::UPD_CMP0: upd_ev = m0;
      timers_pkg::UPD_CMP1: upd_ev = m1;
      timers_pkg::UPD_EITHER: upd_ev = m0 || m1;
      default: upd_ev = (m0 && r_reg.rst_sel == timers_pkg::RST_CMP0) ||
                        (m1 && r_reg.rst_sel == timers_pkg::RST_CMP1) ||
                        (ovf && r_reg.rst_sel == timers_pkg::RST_ROLL);
    endcase
    if (upd_ev) begin
      r_next.cmp0 = r_reg.buf0;
      r_next.cmp1 = r_reg.buf1;
    end
    // R11: enabled interrupt pulses
    r_next.irq = {m1 & r_reg.ien[2], m0 & r_reg.ien[1], ovf & r_reg.ien[0]};
    if (wr_en) begin
      case (wr_idx)
        timers_pkg::IDX_CTRL: begin
          r_next.en = wdata[timers_pkg::F_EN];
          r_next.rst_sel = wdata[timers_pkg::F_RST_SEL +: 2];
          r_next.upd = wdata[timers_pkg::F_UPD +: 2];
          r_next.pact0 = wdata[timers_pkg::F_PACT0 +: 2];
          r_next.pact1 = wdata[timers_pkg::F_PACT1 +: 2];
          r_next.gpio = wdata[timers_pkg::F_GPIO];
          r_next.ien = wdata[timers_pkg::F_IEN +: 3];
          // R5: software counter reset
          if (wdata[timers_pkg::F_SWRST]) begin
            r_next.cnt = '0;
            r_next.pre_cnt = 8'h00;
          end
        end
        timers_pkg::IDX_PRESCALE: r_next.pre = wdata[7:0];
        timers_pkg::IDX_BUF0: r_next.buf0 = wdata[CW-1:0];
        timers_pkg::IDX_BUF1: r_next.buf1 = wdata[CW-1:0];
        default: r_next.en = r_next.en;
      endcase
    end
  end

  // State register; compares start at zero with the counter stopped.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs and read mux
  // ==========================================================
  // R9: pin level readable, or input level in gpio mode.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      timers_pkg::IDX_CTRL: rd_data[12:0] = {r_reg.ien, r_reg.gpio,
        r_reg.pact1, r_reg.pact0, r_reg.upd, r_reg.rst_sel, r_reg.en};
      timers_pkg::IDX_PRESCALE: rd_data[7:0] = r_reg.pre;
      timers_pkg::IDX_BUF0: rd_data[CW-1:0] = r_reg.buf0;
      timers_pkg::IDX_BUF1: rd_data[CW-1:0] = r_reg.buf1;
      timers_pkg::IDX_COUNT: rd_data[CW-1:0] = r_reg.cnt;
      timers_pkg::IDX_ACT0: rd_data[CW-1:0] = r_reg.cmp0;
      timers_pkg::IDX_ACT1: rd_data[CW-1:0] = r_reg.cmp1;
      default: rd_data[0] = r_reg.gpio ? r_reg.sync[1] : r_reg.pin;
    endcase
  end

  assign count = r_reg.cnt;
  assign pin_out = r_reg.pin;
  assign pin_oe = ~r_reg.gpio;
  assign irq = r_reg.irq;

  // ==========================================================
  // Checks
  // ==========================================================
  sw_reset_a: // R5
    assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && wr_idx == timers_pkg::IDX_CTRL && wdata[timers_pkg::F_SWRST]
      |=> r_reg.cnt == '0)
    else $error("software reset did not clear the counter");
  ovf_irq_a: // R11
    assert property (@(posedge clk) disable iff (!rst_n)
      r_reg.en && r_reg.pre_cnt == r_reg.pre && r_reg.cnt == '1 &&
      r_reg.ien[0] |=> irq[0])
    else $error("overflow interrupt missing");
  prescale_step_a: // R18
    assert property (@(posedge clk) disable iff (!rst_n)
      r_reg.cnt != $past(r_reg.cnt) && !$past(wr_en)
      |-> $past(r_reg.pre_cnt == r_reg.pre && r_reg.en))
    else $error("count moved without a prescaler terminal count");

endmodule // pwm_timer_core

// File: pwm_capture_watchdog_timers.sv
// Timer set: one 24-bit PWM/capture timer, four 16-bit PWM timers and a
// watchdog, all reached over APB. Assumes capture pins, timer pins and
// the low-speed oscillator are asynchronous to clk.
//
// Summary of operation
// R1: one 24-bit counter with 8-bit prescaler
// R2: two compares make set and unset events
// R3: compare writes buffered, loaded after match
// R4: capture edge copies count into capture register
// R5: counter reset by rollover, compare or software
// R6: five enabled interrupts on the 24-bit timer
// R7: only second compare acts on pin
// R8: first compare is interrupt only
// R9: pin level readable, or used as input
// R10: four 16-bit counters, prescalers, two compares
// R11: overflow and compare interrupts, each enabled
// R12: compare match applies pin action
// R13: watchdog counts low-speed oscillator ticks
// R14: watchdog expiry resets the processor
// R15: firmware restarts watchdog through key register
// R16: watchdog enable sticks until device reset
// R17: half-interval status flag for watchdog
// R18: prescaler divides by value plus one
// R19: capture pins pass two flip-flops first
// R20: half flag sets at half, clears on restart
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ns
module pwm_capture_watchdog_timers #(
  parameter int WD_W = 16,                  // Watchdog counter width.
  parameter logic [15:0] WD_TERM = 16'hffff // Watchdog terminal count.
) (
  input wire logic clk,                     // Interface clock, 25 MHz.
  input wire logic rst_n,                   // Synchronous reset.
  input wire logic psel,                    // APB select.
  input wire logic penable,                 // APB enable.
  input wire logic pwrite,                  // APB direction.
  input wire logic [11:0] paddr,            // APB byte address.
  input wire logic [31:0] pwdata,           // APB write data.
  output logic [31:0] prdata,               // APB read data.
  output logic pready,                      // APB ready.
  output logic pslverr,                     // APB error, unmapped.
  input wire logic capture_input_0,         // Capture pin 0.
  input wire logic capture_input_1,         // Capture pin 1.
  input wire logic lsosc_clk,               // Low-speed oscillator.
  input wire logic timer_compare_output_pin_in,   // 24-bit pin level.
  output logic timer_compare_output_pin_out,      // 24-bit pin drive.
  output logic timer_compare_output_pin_oe,       // 24-bit pin enable.
  input wire logic [3:0] pwm16_pin_in,      // 16-bit pin levels.
  output logic [3:0] pwm16_pin_out,         // 16-bit pin drives.
  output logic [3:0] pwm16_pin_oe,          // 16-bit pin enables.
  output logic [4:0] irq24,                 // 24-bit timer pulses.
  output logic [11:0] irq16,                // 16-bit timer pulses.
  output logic wd_half,                     // Watchdog half flag.
  output logic proc_reset                   // Processor reset request.
);

  if (WD_W != 16 || WD_TERM < 16'h0002) begin : bad_wd
    $error("watchdog width must be 16 and terminal count at least 2");
  end

  localparam logic [15:0] WD_HALF = WD_TERM >> 1;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] cap0_sync;
    logic [1:0] cap1_sync;
    logic [1:0] ls_sync;
    logic cap0_prev;
    logic cap1_prev;
    logic ls_prev;
    logic [5:0] cap_cfg;
    logic [23:0] cap0;
    logic [23:0] cap1;
    logic [1:0] cap_irq;
    logic wd_en;
    logic [15:0] wd_cnt;
    logic wd_half;
    logic wd_fire;
  } top_s;

  top_s r_reg;
  top_s r_next;

  // ==========================================================
  // Address decode
  // ==========================================================
  logic hit24;
  logic hitcap;
  logic hit16;
  logic hitwd;
  logic [1:0] t16_sel;
  logic [2:0] widx;
  logic mapped;
  logic wr_acc;
  logic [31:0] rd24;
  logic [31:0] rd16 [4];
  logic [23:0] cnt24;
  logic [2:0] irq24_core;
  logic edge0;
  logic edge1;
  logic ls_tick;
  logic restart;

  localparam logic [6:0] T24_WIN = timers_pkg::T24_BASE[11:5];
  localparam logic [7:0] CAP_WIN = timers_pkg::CAP_CFG_OFF[11:4];
  localparam logic [7:0] WD_WIN = timers_pkg::WD_CTRL_OFF[11:4];

  // Decode works on the held address in both APB phases.
  assign hit24 = paddr[11:5] == T24_WIN;
  assign hitcap = paddr[11:4] == CAP_WIN && paddr[3:2] != 2'b11;
  assign hit16 = paddr[11:8] == 4'h0 && paddr[7:6] != 2'b00 &&
                 paddr[7:6] != 2'b11;
  assign hitwd = paddr[11:4] == WD_WIN && paddr[3:2] != 2'b11;
  // Timer k sits at 0x040 + 0x20*k: index is paddr[7:5] less two.
  assign t16_sel = paddr[6:5] + 2'b10;
  assign widx = paddr[4:2];
  assign mapped = hit24 || hitcap || hit16 || hitwd;
  // Writes land only at the access edge where pready is seen high.
  assign wr_acc = psel && penable && r_reg.pready && pwrite && mapped;

  // ==========================================================
  // Timer instances
  // ==========================================================
  // R1: 24-bit timer, compare 0 kept off the pin.
  pwm_timer_core #(.CW(24), .CMP0_PIN(1'b0)) t24 (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_acc && hit24),
    .wr_idx(widx),
    .wdata(pwdata),
    .rd_idx(widx),
    .rd_data(rd24),
    .count(cnt24),
    .pin_in(timer_compare_output_pin_in),
    .pin_out(timer_compare_output_pin_out),
    .pin_oe(timer_compare_output_pin_oe),
    .irq(irq24_core)
  );

  // R10: four 16-bit timers with their own prescalers.
  for (genvar k = 0; k < 4; k++) begin : g16
    pwm_timer_core #(.CW(16), .CMP0_PIN(1'b1)) t16 (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(wr_acc && hit16 && t16_sel == 2'(k)),
      .wr_idx(widx),
      .wdata(pwdata),
      .rd_idx(widx),
      .rd_data(rd16[k]),
      .count(),
      .pin_in(pwm16_pin_in[k]),
      .pin_out(pwm16_pin_out[k]),
      .pin_oe(pwm16_pin_oe[k]),
      .irq(irq16[3*k +: 3])
    );
  end

  // ==========================================================
  // Next state
  // ==========================================================
  // Edge and tick detection read only the second synchroniser stage.
  always_comb begin
    r_next = r_reg;
    // R19: two-stage capture synchronisers
    r_next.cap0_sync = {r_reg.cap0_sync[0], capture_input_0};
    r_next.cap1_sync = {r_reg.cap1_sync[0], capture_input_1};
    r_next.ls_sync = {r_reg.ls_sync[0], lsosc_clk};
    r_next.cap0_prev = r_reg.cap0_sync[1];
    r_next.cap1_prev = r_reg.cap1_sync[1];
    r_next.ls_prev = r_reg.ls_sync[1];
    ls_tick = r_reg.ls_sync[1] && !r_reg.ls_prev;
    edge0 = (r_reg.cap_cfg[timers_pkg::F_EDGE0] &&
             r_reg.cap0_sync[1] && !r_reg.cap0_prev) ||
            (r_reg.cap_cfg[timers_pkg::F_EDGE0 + 1] &&
             !r_reg.cap0_sync[1] && r_reg.cap0_prev);
    edge1 = (r_reg.cap_cfg[timers_pkg::F_EDGE1] &&
             r_reg.cap1_sync[1] && !r_reg.cap1_prev) ||
            (r_reg.cap_cfg[timers_pkg::F_EDGE1 + 1] &&
             !r_reg.cap1_sync[1] && r_reg.cap1_prev);
    // R4: capture copies the 24-bit count
    if (edge0) begin
      r_next.cap0 = cnt24;
    end
    if (edge1) begin
      r_next.cap1 = cnt24;
    end
    // R6: capture interrupt pulses
    r_next.cap_irq = {edge1 && r_reg.cap_cfg[timers_pkg::F_CIEN1],
                      edge0 && r_reg.cap_cfg[timers_pkg::F_CIEN0]};

    // APB: answer in the first access cycle, read data taken at setup.
    r_next.pready = psel && !penable;
    r_next.pslverr = psel && !penable && !mapped;
    if (psel && !penable) begin
      r_next.prdata = timers_pkg::RDATA_RST;
      if (hit24) begin
        r_next.prdata = rd24;
      end else if (hit16) begin
        r_next.prdata = rd16[t16_sel];
      end else if (hitcap) begin
        case (paddr[3:2])
          2'b00: r_next.prdata[5:0] = r_reg.cap_cfg;
          2'b01: r_next.prdata[23:0] = r_reg.cap0;
          default: r_next.prdata[23:0] = r_reg.cap1;
        endcase
      end else if (hitwd) begin
        case (paddr[3:2])
          2'b00: r_next.prdata[timers_pkg::F_WD_EN] = r_reg.wd_en;
          2'b01: r_next.prdata = timers_pkg::RDATA_RST;
          default: r_next.prdata[1:0] = {r_reg.wd_fire, r_reg.wd_half};
        endcase
      end
    end

    if (wr_acc && hitcap && paddr[3:2] == 2'b00) begin
      r_next.cap_cfg = pwdata[5:0];
    end

    // R16: enable only ever sets from software
    if (wr_acc && hitwd && paddr[3:2] == 2'b00) begin
      r_next.wd_en = r_reg.wd_en | pwdata[timers_pkg::F_WD_EN];
    end

    // R15: restart bit in key register
    restart = wr_acc && hitwd && paddr[3:2] == 2'b01 &&
              pwdata[timers_pkg::F_WD_RESTART];

    // R13: watchdog counts oscillator ticks
    if (restart) begin
      r_next.wd_cnt = 16'h0000;
    end else if (r_reg.wd_en && ls_tick && !r_reg.wd_fire) begin
      r_next.wd_cnt = r_reg.wd_cnt + 16'h0001;
    end
    // R20: half flag, set wins over restart
    r_next.wd_half = (r_reg.wd_half && !restart) ||
                     (r_reg.wd_en && ls_tick && r_reg.wd_cnt == WD_HALF);

    // R14: expiry raises processor reset
    if (r_reg.wd_en && ls_tick && r_reg.wd_cnt == WD_TERM && !restart) begin
      r_next.wd_fire = 1'b1;
    end
  end

  // The reset request holds until the device reset clears it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  // R8: compare 0 of the 24-bit timer feeds only this vector.
  assign irq24 = {r_reg.cap_irq, irq24_core};
  // R17: half-interval flag visible as a port and in status.
  assign wd_half = r_reg.wd_half;
  assign proc_reset = r_reg.wd_fire;

  // ==========================================================
  // Checks
  // ==========================================================
  apb_ready_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  capture_copy_a: // R4
    assert property (@(posedge clk) disable iff (!rst_n)
      r_reg.cap_cfg[timers_pkg::F_EDGE0] && r_reg.cap0_sync[1] &&
      !r_reg.cap0_prev |=> r_reg.cap0 == $past(cnt24))
    else $error("capture 0 missed the count");
  capture_sync_a: // R19
    assert property (@(posedge clk) disable iff (!rst_n)
      r_reg.cap1_sync[1] != r_reg.cap1_prev
      |-> $past(capture_input_1, 2) == r_reg.cap1_sync[1])
    else $error("capture path is not two stages deep");
  wd_sticky_a: // R16
    assert property (@(posedge clk) disable iff (!rst_n)
      r_reg.wd_en |=> r_reg.wd_en)
    else $error("watchdog enable cleared without reset");
  wd_restart_a: // R15
    assert property (@(posedge clk) disable iff (!rst_n)
      wr_acc && hitwd && paddr[3:2] == 2'b01 && pwdata[0]
      |=> r_reg.wd_cnt == 16'h0000)
    else $error("restart did not clear the watchdog");
  wd_half_a: // R20
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(r_reg.wd_half) |-> $past(r_reg.wd_cnt) == WD_HALF)
    else $error("half flag set away from half count");
  wd_expire_a: // R14
    assert property (@(posedge clk) disable iff (!rst_n)
      r_reg.wd_en && ls_tick && r_reg.wd_cnt == WD_TERM && !restart
      |=> proc_reset [*3])
    else $error("watchdog expiry did not hold processor reset");
  unmapped_err_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      psel && !penable && !mapped |=> pslverr && pready)
    else $error("unmapped address not flagged");

endmodule // pwm_capture_watchdog_timers

// File: pin_partner.sv
// Far side of the timer set: capture pins, timer pin levels, slow clock.
// Assumes the bench sets ext, ext24 and the capture pins between edges.
`timescale 1ns/1ns
module pin_partner (
  output logic cap0, // Capture pin 0.
  output logic cap1, // Capture pin 1.
  output logic osc, // Slow oscillator.
  input wire logic t_out, // 24-bit pin drive.
  input wire logic t_oe, // 24-bit pin enable.
  output logic t_in, // 24-bit pin level.
  input wire logic [3:0] p_out, // 16-bit pin drives.
  input wire logic [3:0] p_oe, // 16-bit pin enables.
  output logic [3:0] p_in // 16-bit pin levels.
);
  logic [3:0] ext = 4'h0;
  logic ext24 = 1'b0;
  // A driven pin shows its driver; a released one shows the outside.
  assign t_in = t_oe ? t_out : ext24;
  assign p_in = (p_oe & p_out) | (~p_oe & ext);
  initial begin
    cap0 = 1'b0;
    cap1 = 1'b0;
    osc = 1'b0;
  end
  // The oscillator pulses only on request, far slower than clk.
  task ticks(input int n);
    repeat (n) begin
      #400 osc = 1'b1;
      #400 osc = 1'b0;
    end
  endtask
endmodule // pin_partner

// File: tb_top.sv
// Self-checking bench for the timer set over APB.
// Assumes pin_partner drives every pin and the slow oscillator.
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic c0, c1, osc, ti, to, toe, wd_half, proc_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, r2, c;
  logic [3:0] pi, po, poe, v;
  logic p;
  logic [16:0] s = 0;
  wire [16:0] iq;
  int fail_count, n_tests, cyc, k, a;
  int pl[2] = '{0, 2};
  int acts[5] = '{1, 3, 2, 3, 0};
  pwm_capture_watchdog_timers #(.WD_TERM(16'h0010))
    pwm_capture_watchdog_timers_i (.clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .capture_input_0(c0), .capture_input_1(c1), .lsosc_clk(osc),
    .timer_compare_output_pin_in(ti), .timer_compare_output_pin_out(to),
    .timer_compare_output_pin_oe(toe), .pwm16_pin_in(pi),
    .pwm16_pin_out(po), .pwm16_pin_oe(poe), .irq24(iq[4:0]),
    .irq16(iq[16:5]), .wd_half, .proc_reset);
  pin_partner pin_partner_i (.cap0(c0), .cap1(c1), .osc, .t_out(to),
    .t_oe(toe), .t_in(ti), .p_out(po), .p_oe(poe), .p_in(pi));
  // ==========================================================
  // Clock, timeout and shared tasks
  // ==========================================================
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // A hang ends the run as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // Latch every interrupt pulse.
  always @(posedge clk) if (rst_n) s <= s | iq;
  task cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; an edge passes after release so strobes never clash.
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [11:0] ad(input int t, input logic [2:0] i);
    logic [11:0] b;
    b = (t < 0) ? timers_pkg::T24_BASE
        : timers_pkg::T16_BASE + 12'(t) * timers_pkg::T16_STRIDE;
    return b + {7'h00, i, 2'b00};
  endfunction
  function automatic logic nxt(input logic q, input int op);
    return (op == 1) ? 1'b1 : (op == 2) ? 1'b0 : (op == 3) ? ~q : q;
  endfunction
  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    void'($urandom(32'h70d6));
    cy(3);
    rst_n <= 1;
    @(posedge clk);
    apb(0, 12'h0fc, 0);
    chk("unmapped", 1, err);
    apb(0, ad(-1, timers_pkg::IDX_PRESCALE), 0);
    chk("presc_rst", 0, r);
    // Count step over two reads three edges apart: 3/(N+1).
    foreach (pl[j]) begin
      k = (j == 0) ? -1 : $urandom_range(3);
      apb(1, ad(k, timers_pkg::IDX_PRESCALE), pl[j]);
      apb(1, ad(k, timers_pkg::IDX_CTRL), 1);
      apb(0, ad(k, timers_pkg::IDX_COUNT), 0);
      r2 = r;
      apb(0, ad(k, timers_pkg::IDX_COUNT), 0);
      chk("step", 32'(3 / (pl[j] + 1)), r - r2);
      apb(1, ad(k, timers_pkg::IDX_CTRL), 0);
    end
    // Software restart meets compare 0, then compare 1, at count 0.
    apb(1, ad(-1, timers_pkg::IDX_CTRL), 32'h10021);
    cy(6);
    chk("t24_cmp0", 0, to);
    apb(1, ad(-1, timers_pkg::IDX_CTRL), 32'h11881);
    cy(6);
    chk("t24_cmp1", 1, to);
    k = $urandom_range(3);
    p = 0;
    foreach (acts[j]) begin
      apb(1, ad(k, timers_pkg::IDX_CTRL), 32'h11001 | (acts[j] << 7));
      cy(8);
      p = nxt(p, acts[j]);
      chk("pin16", p, po[k]);
    end
    chk("irq16", 1, s[3*k+7]);
    apb(1, ad(k, timers_pkg::IDX_BUF1), 5);
    apb(0, ad(k, timers_pkg::IDX_ACT1), 0);
    chk("shadow_hold", 0, r);
    apb(1, ad(k, timers_pkg::IDX_CTRL), 32'h10001);
    cy(4);
    apb(0, ad(k, timers_pkg::IDX_ACT1), 0);
    chk("shadow_load", 5, r);
    // Released pin read back as an input.
    v = 4'($urandom);
    pin_partner_i.ext <= v;
    apb(1, ad(k, timers_pkg::IDX_CTRL), 32'h200);
    cy(4);
    apb(0, ad(k, timers_pkg::IDX_STATUS), 0);
    chk("gpio", v[k], r[0]);
    chk("gpio_oe", 0, poe[k]);
    // Pin 0 captures on rise, pin 1 only on fall.
    apb(1, timers_pkg::CAP_CFG_OFF, 32'h39);
    apb(0, ad(-1, timers_pkg::IDX_COUNT), 0);
    c = r;
    pin_partner_i.cap0 <= 1;
    pin_partner_i.cap1 <= 1;
    cy(8);
    apb(0, timers_pkg::CAP0_DATA_OFF, 0);
    chk("cap0", 1, r > c && r - c < 12);
    apb(0, timers_pkg::CAP1_DATA_OFF, 0);
    chk("cap1_rise", 0, r);
    pin_partner_i.cap1 <= 0;
    cy(8);
    apb(0, timers_pkg::CAP1_DATA_OFF, 0);
    chk("cap1_fall", 1, r > c);
    chk("irq24", 32'h1e, s[4:0]);
    // Watchdog: half flag, restart, then sticky enable and expiry.
    apb(1, timers_pkg::WD_CTRL_OFF, 1);
    pin_partner_i.ticks(8);
    cy(6);
    chk("half_early", 0, wd_half);
    pin_partner_i.ticks(1);
    cy(6);
    chk("half", 1, wd_half);
    apb(1, timers_pkg::WD_KEY_OFF, 1);
    chk("half_clr", 0, wd_half);
    apb(1, timers_pkg::WD_CTRL_OFF, 0);
    pin_partner_i.ticks(16);
    cy(6);
    chk("no_expiry", 0, proc_reset);
    pin_partner_i.ticks(1);
    cy(6);
    chk("expiry", 1, proc_reset);
    end_sim();
  end
endmodule // tb_top
